// file: rtl/dxa_params.svh
// Purpose: constants for the transfer controller working-state block
// Assumes: 32-bit classic Wishbone register port, byte addresses
// Notes: every field position and offset, and the 32- and 16-bit reset values, used by the logic live here
`ifndef DXA_PARAMS_SVH
`define DXA_PARAMS_SVH

`define DXA_RST_WORD 32'h0000_0000
`define DXA_ZERO16 16'h0000
`define DXA_ONE16 16'h0001
// options word field positions
`define DXA_OPT_CHEN 22
`define DXA_OPT_IEN 20
`define DXA_OPT_CODE 17:12
`define DXA_OPT_FIFO_WIDTH_SEL 10:8
`define DXA_OPT_PRI 6:4
`define DXA_OPT_DAM 1
`define DXA_OPT_SAM 0
// bits that software may change in a destination options word
`define DXA_OPT_WMASK 32'h0053_F773
// privilege proxy word
`define DXA_PRX_PRIVILEGE_LEVEL 8
`define DXA_PRX_PID 3:0
// source-active register offsets
`define DXA_SA_OPT 8'h00
`define DXA_SA_SRC 8'h04
`define DXA_SA_CNT 8'h08
`define DXA_SA_DST 8'h0C
`define DXA_SA_BIDX 8'h10
`define DXA_SA_PRX 8'h14
`define DXA_SA_RLD 8'h18
`define DXA_SA_SREF 8'h1C
`define DXA_SA_DREF 8'h20
// destination sets: base, stride shift and offsets inside one set
`define DXA_DS_BASE 8'h40
`define DXA_DS_SHIFT 5
`define DXA_DS_OPT 5'h00
`define DXA_DS_RLD 5'h04
`define DXA_DS_SREF 5'h08
`define DXA_DS_DREF 5'h0C
// default read/write command size in increment mode, bytes
`define DXA_BURST 16'h0010

`endif

// file: rtl/dxa_pkg.sv
// Purpose: shared types and helpers for the transfer controller working state
// Assumes: dxa_params.svh supplies field positions
// Notes: chunk sizing is shared by the read and the write side
package dxa_pkg;
`include "dxa_params.svh"

	// one transfer request as submitted by the channel controller
	typedef struct packed {
		logic [31:0] opt;
		logic [31:0] src;
		logic [31:0] dst;
		logic [15:0] first_dim_byte_count;
		logic [15:0] array_count;
		logic [15:0] sidx;
		logic [15:0] didx;
		logic privilege_level;
		logic [3:0] pid;
	} dxa_tr_t;

	// one read or write command towards an endpoint
	typedef struct packed {
		logic [31:0] addr;
		logic [15:0] len;
		logic [2:0] transfer_priority;
		logic privilege_level;
		logic [3:0] pid;
	} dxa_cmd_t;

	// completion report
	typedef struct packed {
		logic [5:0] code;
		logic chain;
		logic irq;
	} dxa_done_t;

	typedef enum logic {
		DXA_IDLE = 1'b0,
		DXA_READ = 1'b1
	} dxa_src_st_t;

	// fifo width select: 0..5 give 1..32 bytes; reserved codes fall back to one byte
	function automatic logic [15:0] dxa_fifo_bytes(input logic [2:0] sel);
		logic [15:0] r;
		r = `DXA_ONE16;
		if (sel <= 3'h5) begin
			r = `DXA_ONE16 << sel;
		end
		return r;
	endfunction

	// bytes moved by the next command: capped by burst, or by fifo width in wrap mode
	function automatic logic [15:0] dxa_chunk(input logic [15:0] first_dim_byte_count, input logic wrap,
		input logic [2:0] fw, input logic [15:0] burst);
		logic [15:0] lim;
		lim = wrap ? dxa_fifo_bytes(fw) : burst;
		return (first_dim_byte_count < lim) ? first_dim_byte_count : lim;
	endfunction
endpackage

// file: rtl/dxa_active_state.sv
// Purpose: working state of one DMA transfer controller: source-active set and destination sets
// Assumes: single clock, synchronous active-high reset, requests from logic on the same clock
// Notes: registers are read over classic Wishbone; only destination options bits are writable
// What this block does
// - priority field 3 bits: 0 highest, 1..6 middle, 7 lowest; passed on each command.
// - destination mode 0 increments within an array, 1 wraps at the fifo width.
// - source mode 0 increments within an array, 1 wraps at the fifo width.
// - keep a 32-bit current source address updated per read by source mode.
// - 16-bit remaining byte count falls per read, array count per completed array; both zero at end.
// - array count is number of arrays, each one byte count long.
// - keep a 16-bit source stride between starts of successive source arrays.
// - capture privilege level at submit; present it on every read and write.
// - capture 4-bit requester identity at submit; attach it to every command.
// - keep original byte count as reload in both sets; restore after each array but the last.
// - keep 32-bit source base address of the array currently being read.
// - destination set source base always reads as zero.
// - keep 32-bit destination base address of the array currently being written.
// - one destination options register per destination entry, index zero upward.
// - options bit 22 enables completion chaining when set.
// - fifo width codes 0..5 mean 8..256 bits; 6 and 7 reserved.
// - carry a 6-bit completion code per request, reported at completion.
`include "dxa_params.svh"

module dxa_active_state
	import dxa_pkg::*;
#(
	parameter int DEPTH = 4,
	parameter logic [15:0] BURST = `DXA_BURST
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	input wire logic tr_valid_i,
	input wire dxa_tr_t tr_i,
	output logic tr_ready_o,
	output logic rd_valid_o,
	output dxa_cmd_t rd_cmd_o,
	input wire logic rd_ready_i,
	output logic wr_valid_o,
	output dxa_cmd_t wr_cmd_o,
	input wire logic wr_ready_i,
	output logic done_o,
	output dxa_done_t done_info_o
);
	// pointer width; a build with a single set still needs one pointer bit
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	// occupancy is one bit wider than a pointer, so a full ring of DEPTH sets differs from an empty one
	localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
	// last set index, where the ring pointers go back to zero
	localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

	// source-active set
	// one request at a time; sa_slot_q remembers which destination set it feeds
	dxa_src_st_t st_q, st_d;
	logic [31:0] sa_opt_q, sa_opt_d, sa_src_q, sa_src_d, sa_ref_q, sa_ref_d;
	logic [15:0] sa_first_dim_byte_count_q, sa_first_dim_byte_count_d, sa_array_count_q, sa_array_count_d, sa_rld_q, sa_rld_d;
	logic [15:0] sa_sidx_q, sa_sidx_d;
	logic sa_privilege_level_q, sa_privilege_level_d;
	logic [3:0] sa_pid_q, sa_pid_d;
	logic [PW-1:0] sa_slot_q, sa_slot_d;
	// destination sets
	// ds_rdy_q marks a set whose reads are all issued, so its writes may start
	// the sets form a ring: wp_q fills, hp_q drains, cnt_q counts the sets in use
	logic [31:0] ds_opt_q [DEPTH], ds_opt_d [DEPTH];
	logic [31:0] ds_dst_q [DEPTH], ds_dst_d [DEPTH];
	logic [31:0] ds_ref_q [DEPTH], ds_ref_d [DEPTH];
	logic [15:0] ds_first_dim_byte_count_q [DEPTH], ds_first_dim_byte_count_d [DEPTH];
	logic [15:0] ds_array_count_q [DEPTH], ds_array_count_d [DEPTH];
	logic [15:0] ds_rld_q [DEPTH], ds_rld_d [DEPTH];
	logic [15:0] ds_didx_q [DEPTH], ds_didx_d [DEPTH];
	logic ds_privilege_level_q [DEPTH], ds_privilege_level_d [DEPTH];
	logic [3:0] ds_pid_q [DEPTH], ds_pid_d [DEPTH];
	logic ds_rdy_q [DEPTH], ds_rdy_d [DEPTH];
	logic [PW-1:0] wp_q, wp_d, hp_q, hp_d;
	logic [PW:0] cnt_q, cnt_d;
	logic done_q, done_d;
	dxa_done_t dinfo_q, dinfo_d;
	// bus
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;

	// decode helpers, all combinational from flops and input ports
	logic push, pop, rd_fire, wr_fire, bus_req, hd_busy;
	logic [15:0] rd_len, wr_len;
	logic [7:0] ds_off;
	logic [PW-1:0] ds_idx;
	logic ds_hit;
	logic [31:0] bmask;

	// request intake stalls while a read is running or all destination sets are taken
	// the channel controller holds its request while ready is low, so nothing is dropped
	assign tr_ready_o = (st_q == DXA_IDLE) && (cnt_q < DEPTH_C);
	assign push = tr_valid_i && tr_ready_o;
	assign hd_busy = (cnt_q != '0) && ds_rdy_q[hp_q];

	// read command: all fields from the source-active flops
	// len is the only decoded field; reserved fifo codes fall back to byte moves
	assign rd_len = dxa_chunk(sa_first_dim_byte_count_q, sa_opt_q[`DXA_OPT_SAM], sa_opt_q[`DXA_OPT_FIFO_WIDTH_SEL], BURST);
	assign rd_valid_o = (st_q == DXA_READ) && (sa_first_dim_byte_count_q != `DXA_ZERO16) && (sa_array_count_q != `DXA_ZERO16);
	assign rd_fire = rd_valid_o && rd_ready_i;
	assign rd_cmd_o = '{addr: sa_src_q, len: rd_len, transfer_priority: sa_opt_q[`DXA_OPT_PRI],
		privilege_level: sa_privilege_level_q, pid: sa_pid_q};

	// write command from the head destination set, only once its reads are done
	// writes never overtake the reads of their own set: that data is not in flight yet
	assign wr_len = dxa_chunk(ds_first_dim_byte_count_q[hp_q], ds_opt_q[hp_q][`DXA_OPT_DAM], ds_opt_q[hp_q][`DXA_OPT_FIFO_WIDTH_SEL],
		BURST);
	assign wr_valid_o = hd_busy && (ds_first_dim_byte_count_q[hp_q] != `DXA_ZERO16) && (ds_array_count_q[hp_q] != `DXA_ZERO16);
	assign wr_fire = wr_valid_o && wr_ready_i;
	assign wr_cmd_o = '{addr: ds_dst_q[hp_q], len: wr_len, transfer_priority: ds_opt_q[hp_q][`DXA_OPT_PRI],
		privilege_level: ds_privilege_level_q[hp_q], pid: ds_pid_q[hp_q]};
	// head set retires on its last write, or at once when it carried a zero count
	assign pop = hd_busy && (wr_fire ? (wr_len == ds_first_dim_byte_count_q[hp_q]) && (ds_array_count_q[hp_q] == `DXA_ONE16)
		: !wr_valid_o);

	// source-active next state
	always_comb begin
		st_d = st_q;
		sa_opt_d = sa_opt_q;
		sa_src_d = sa_src_q;
		sa_ref_d = sa_ref_q;
		sa_first_dim_byte_count_d = sa_first_dim_byte_count_q;
		sa_array_count_d = sa_array_count_q;
		sa_rld_d = sa_rld_q;
		sa_sidx_d = sa_sidx_q;
		sa_privilege_level_d = sa_privilege_level_q;
		sa_pid_d = sa_pid_q;
		sa_slot_d = sa_slot_q;
		case (st_q)
			DXA_IDLE: begin
				if (push) begin
					st_d = DXA_READ;
					sa_opt_d = tr_i.opt;
					sa_src_d = tr_i.src;
					sa_ref_d = tr_i.src;
					sa_first_dim_byte_count_d = tr_i.first_dim_byte_count;
					sa_array_count_d = tr_i.array_count;
					sa_rld_d = tr_i.first_dim_byte_count;
					sa_sidx_d = tr_i.sidx;
					sa_privilege_level_d = tr_i.privilege_level;
					sa_pid_d = tr_i.pid;
					sa_slot_d = wp_q;
				end
			end
			DXA_READ: begin
				if (!rd_valid_o) begin
					st_d = DXA_IDLE;
				end else if (rd_fire) begin
					// last chunk of an array: reload the byte count and step the base by the stride
					if (rd_len == sa_first_dim_byte_count_q) begin
						sa_array_count_d = sa_array_count_q - `DXA_ONE16;
						// after the last array both counts stay at zero for software to see
						if (sa_array_count_q == `DXA_ONE16) begin
							sa_first_dim_byte_count_d = `DXA_ZERO16;
						end else begin
							sa_first_dim_byte_count_d = sa_rld_q;
							// the stride is signed, so arrays may also be walked downwards
							sa_ref_d = sa_ref_q + {{16{sa_sidx_q[15]}}, sa_sidx_q};
							sa_src_d = sa_ref_q + {{16{sa_sidx_q[15]}}, sa_sidx_q};
						end
					end else begin
						sa_first_dim_byte_count_d = sa_first_dim_byte_count_q - rd_len;
						// wrap mode returns to the array base once a fifo width is consumed
						sa_src_d = sa_opt_q[`DXA_OPT_SAM] ? sa_ref_q : sa_src_q + {`DXA_ZERO16, rd_len};
					end
				end
			end
			default: st_d = DXA_IDLE;
		endcase
	end

	// source-active registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= DXA_IDLE;
			sa_opt_q <= `DXA_RST_WORD;
			sa_src_q <= `DXA_RST_WORD;
			sa_ref_q <= `DXA_RST_WORD;
			sa_first_dim_byte_count_q <= `DXA_ZERO16;
			sa_array_count_q <= `DXA_ZERO16;
			sa_rld_q <= `DXA_ZERO16;
			sa_sidx_q <= `DXA_ZERO16;
			sa_privilege_level_q <= 1'b0;
			sa_pid_q <= 4'h0;
			sa_slot_q <= '0;
		end else begin
			st_q <= st_d;
			sa_opt_q <= sa_opt_d;
			sa_src_q <= sa_src_d;
			sa_ref_q <= sa_ref_d;
			sa_first_dim_byte_count_q <= sa_first_dim_byte_count_d;
			sa_array_count_q <= sa_array_count_d;
			sa_rld_q <= sa_rld_d;
			sa_sidx_q <= sa_sidx_d;
			sa_privilege_level_q <= sa_privilege_level_d;
			sa_pid_q <= sa_pid_d;
			sa_slot_q <= sa_slot_d;
		end
	end

	// bus decode shared by read mux and options write
	// ack_q keeps the held second cycle of a request from being taken twice
	assign bus_req = cyc_i && stb_i && !ack_q;
	assign ds_off = adr_i - `DXA_DS_BASE;
	assign ds_idx = PW'(ds_off >> `DXA_DS_SHIFT);
	assign ds_hit = (adr_i >= `DXA_DS_BASE) && ((ds_off >> `DXA_DS_SHIFT) < 8'(DEPTH));
	assign bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}} & `DXA_OPT_WMASK;

	// destination sets next state; a submit into a set wins over a software write to it
	always_comb begin
		ds_opt_d = ds_opt_q;
		ds_dst_d = ds_dst_q;
		ds_ref_d = ds_ref_q;
		ds_first_dim_byte_count_d = ds_first_dim_byte_count_q;
		ds_array_count_d = ds_array_count_q;
		ds_rld_d = ds_rld_q;
		ds_didx_d = ds_didx_q;
		ds_privilege_level_d = ds_privilege_level_q;
		ds_pid_d = ds_pid_q;
		ds_rdy_d = ds_rdy_q;
		wp_d = wp_q;
		hp_d = hp_q;
		done_d = 1'b0;
		dinfo_d = dinfo_q;
		// software may only change an options word; every other place is read-only
		if (bus_req && we_i && ds_hit && (ds_off[4:0] == `DXA_DS_OPT)) begin
			ds_opt_d[ds_idx] = (ds_opt_q[ds_idx] & ~bmask) | (dat_i & bmask);
		end
		// the source side has issued its last read for the set it feeds
		if (st_q == DXA_READ && !rd_valid_o) begin
			ds_rdy_d[sa_slot_q] = 1'b1;
		end
		// same array walk as the read side, on the write address
		if (wr_fire) begin
			if (wr_len == ds_first_dim_byte_count_q[hp_q]) begin
				ds_array_count_d[hp_q] = ds_array_count_q[hp_q] - `DXA_ONE16;
				if (ds_array_count_q[hp_q] == `DXA_ONE16) begin
					ds_first_dim_byte_count_d[hp_q] = `DXA_ZERO16;
				end else begin
					ds_first_dim_byte_count_d[hp_q] = ds_rld_q[hp_q];
					ds_ref_d[hp_q] = ds_ref_q[hp_q] + {{16{ds_didx_q[hp_q][15]}}, ds_didx_q[hp_q]};
					ds_dst_d[hp_q] = ds_ref_q[hp_q] + {{16{ds_didx_q[hp_q][15]}}, ds_didx_q[hp_q]};
				end
			end else begin
				ds_first_dim_byte_count_d[hp_q] = ds_first_dim_byte_count_q[hp_q] - wr_len;
				ds_dst_d[hp_q] = ds_opt_q[hp_q][`DXA_OPT_DAM] ? ds_ref_q[hp_q]
					: ds_dst_q[hp_q] + {`DXA_ZERO16, wr_len};
			end
		end
		// retire the head set; it keeps its final values for debug reads
		if (pop) begin
			ds_rdy_d[hp_q] = 1'b0;
			hp_d = (hp_q == LAST_C) ? '0 : hp_q + 1'b1;
			done_d = 1'b1;
			dinfo_d = '{code: ds_opt_q[hp_q][`DXA_OPT_CODE],
				chain: ds_opt_q[hp_q][`DXA_OPT_CHEN], irq: ds_opt_q[hp_q][`DXA_OPT_IEN]};
		end
		// a new request takes the free set at the write pointer
		if (push) begin
			ds_opt_d[wp_q] = tr_i.opt;
			ds_dst_d[wp_q] = tr_i.dst;
			ds_ref_d[wp_q] = tr_i.dst;
			ds_first_dim_byte_count_d[wp_q] = tr_i.first_dim_byte_count;
			ds_array_count_d[wp_q] = tr_i.array_count;
			ds_rld_d[wp_q] = tr_i.first_dim_byte_count;
			ds_didx_d[wp_q] = tr_i.didx;
			ds_privilege_level_d[wp_q] = tr_i.privilege_level;
			ds_pid_d[wp_q] = tr_i.pid;
			ds_rdy_d[wp_q] = 1'b0;
			wp_d = (wp_q == LAST_C) ? '0 : wp_q + 1'b1;
		end
		// a push and a pop in one cycle leave the count as it is
		cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
	end

	// destination set registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				ds_opt_q[i] <= `DXA_RST_WORD;
				ds_dst_q[i] <= `DXA_RST_WORD;
				ds_ref_q[i] <= `DXA_RST_WORD;
				ds_first_dim_byte_count_q[i] <= `DXA_ZERO16;
				ds_array_count_q[i] <= `DXA_ZERO16;
				ds_rld_q[i] <= `DXA_ZERO16;
				ds_didx_q[i] <= `DXA_ZERO16;
				ds_privilege_level_q[i] <= 1'b0;
				ds_pid_q[i] <= 4'h0;
				ds_rdy_q[i] <= 1'b0;
			end
			wp_q <= '0;
			hp_q <= '0;
			cnt_q <= '0;
			done_q <= 1'b0;
			dinfo_q <= '0;
		end else begin
			ds_opt_q <= ds_opt_d;
			ds_dst_q <= ds_dst_d;
			ds_ref_q <= ds_ref_d;
			ds_first_dim_byte_count_q <= ds_first_dim_byte_count_d;
			ds_array_count_q <= ds_array_count_d;
			ds_rld_q <= ds_rld_d;
			ds_didx_q <= ds_didx_d;
			ds_privilege_level_q <= ds_privilege_level_d;
			ds_pid_q <= ds_pid_d;
			ds_rdy_q <= ds_rdy_d;
			wp_q <= wp_d;
			hp_q <= hp_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
			dinfo_q <= dinfo_d;
		end
	end
	assign done_o = done_q;
	assign done_info_o = dinfo_q;

	// register read mux; unmapped addresses answer with zero data
	// every address is acked; unmapped places also ignore writes
	always_comb begin
		ack_d = bus_req;
		rdat_d = `DXA_RST_WORD;
		if (ds_hit) begin
			case (ds_off[4:0])
				`DXA_DS_OPT: rdat_d = ds_opt_q[ds_idx] & `DXA_OPT_WMASK;
				`DXA_DS_RLD: rdat_d = {`DXA_ZERO16, ds_rld_q[ds_idx]};
				`DXA_DS_SREF: rdat_d = `DXA_RST_WORD;
				`DXA_DS_DREF: rdat_d = ds_ref_q[ds_idx];
				default: rdat_d = `DXA_RST_WORD;
			endcase
		end else begin
			case (adr_i)
				`DXA_SA_OPT: rdat_d = sa_opt_q & `DXA_OPT_WMASK;
				`DXA_SA_SRC: rdat_d = sa_src_q;
				`DXA_SA_CNT: rdat_d = {sa_array_count_q, sa_first_dim_byte_count_q};
				`DXA_SA_DST: rdat_d = `DXA_RST_WORD;
				`DXA_SA_BIDX: rdat_d = {`DXA_ZERO16, sa_sidx_q};
				`DXA_SA_PRX: begin
					// reserved bits of the proxy word stay at zero from the default above
					rdat_d[`DXA_PRX_PRIVILEGE_LEVEL] = sa_privilege_level_q;
					rdat_d[`DXA_PRX_PID] = sa_pid_q;
				end
				`DXA_SA_RLD: rdat_d = {`DXA_ZERO16, sa_rld_q};
				`DXA_SA_SREF: rdat_d = sa_ref_q;
				`DXA_SA_DREF: rdat_d = `DXA_RST_WORD;
				default: rdat_d = `DXA_RST_WORD;
			endcase
		end
		// dat_o holds the last answer while no request is pending
		if (!bus_req) begin
			rdat_d = rdat_q;
		end
	end

	// bus registers: answer in the cycle after the request, ack lasts a single cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdat_q <= `DXA_RST_WORD;
		end else begin
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end
	assign ack_o = ack_q;
	assign dat_o = rdat_q;
endmodule

// file: testbench/dxa_active_state_asserts.sv
// Purpose: port-level checks of the transfer working-state block
// Assumes: one clock, synchronous active-high reset
// Notes: the read side works on one request at a time, so a copy of it is enough
module dxa_active_state_asserts
	import dxa_pkg::*;
#(
	parameter logic [15:0] BURST = 16'h0010
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic tr_valid_i,
	input wire dxa_tr_t tr_i,
	input wire logic tr_ready_o,
	input wire logic rd_valid_o,
	input wire dxa_cmd_t rd_cmd_o,
	input wire logic rd_ready_i,
	input wire logic wr_valid_o,
	input wire dxa_cmd_t wr_cmd_o,
	input wire logic wr_ready_i,
	input wire logic done_o,
	input wire dxa_done_t done_info_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] opt_q, opt_d;
	logic [4:0] who_q, who_d;
	logic [15:0] fb;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// copy of the accepted request and its fifo width in bytes
	always_comb begin
		opt_d = opt_q;
		who_d = who_q;
		if (tr_valid_i && tr_ready_o) begin
			opt_d = tr_i.opt;
			who_d = {tr_i.privilege_level, tr_i.pid};
		end
		fb = (opt_q[10:8] > 3'h5) ? 16'h0001 : 16'h0001 << opt_q[10:8];
	end
	always_ff @(posedge clk_i) begin
		opt_q <= rst_i ? 32'h0 : opt_d;
		who_q <= rst_i ? 5'h0 : who_d;
	end
	a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus request not acknowledged next cycle");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_rd_held: assert property (rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_cmd_o))
		else $error("read command changed before taken");
	a_first_read: assert property (tr_valid_i && tr_ready_o && tr_i.first_dim_byte_count != 16'h0 && tr_i.array_count != 16'h0
		|=> rd_valid_o && rd_cmd_o.addr == $past(tr_i.src)) else $error("first read not at source address");
	a_increment_addressing_len: assert property (rd_valid_o && !opt_q[0] |-> rd_cmd_o.len != 16'h0 && rd_cmd_o.len <= BURST)
		else $error("increment read length out of range");
	a_wrap_len: assert property (rd_valid_o && opt_q[0] |-> rd_cmd_o.len != 16'h0 && rd_cmd_o.len <= fb)
		else $error("wrap read exceeds fifo width");
	a_rd_owner: assert property (rd_valid_o |-> {rd_cmd_o.privilege_level, rd_cmd_o.pid} == who_q)
		else $error("read privilege or requester wrong");
	a_rd_prio: assert property (rd_valid_o |-> rd_cmd_o.transfer_priority == opt_q[6:4])
		else $error("read priority wrong");
	a_busy_take: assert property (tr_valid_i && tr_ready_o && tr_i.first_dim_byte_count != 16'h0 && tr_i.array_count != 16'h0
		|=> !tr_ready_o) else $error("request accepted while reading");
	c_wrap_rd: cover property (rd_valid_o && rd_ready_i && opt_q[0]);
	c_wr: cover property (wr_valid_o && wr_ready_i);
	c_done_chain: cover property (done_o && done_info_o.chain);
endmodule

bind dxa_active_state dxa_active_state_asserts #(.BURST(BURST)) i_dxa_active_state_asserts (.*);

// file: testbench/dxa_endpoint_model.sv
// Purpose: memory endpoint model taking read and write commands
// Assumes: the block holds each command until ready is sampled high
// Notes: slow_i takes one command in four, hold_wr_i parks all writes
module dxa_endpoint_model
	import dxa_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	input wire logic hold_wr_i,
	input wire logic rd_valid_i,
	input wire dxa_cmd_t rd_cmd_i,
	input wire logic wr_valid_i,
	input wire dxa_cmd_t wr_cmd_i,
	output logic rd_ready_o,
	output logic wr_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] tick_q;
	dxa_cmd_t rd_log[$];
	dxa_cmd_t wr_log[$];
	// a slow endpoint answers only when the tick wraps, so commands must stand
	assign rd_ready_o = !slow_i || tick_q == 2'h3;
	assign wr_ready_o = !hold_wr_i && rd_ready_o;
	// log every command taken, in order
	always @(posedge clk_i) begin
		tick_q <= rst_i ? 2'h0 : tick_q + 2'h1;
		if (rd_valid_i && rd_ready_o) begin
			rd_log.push_back(rd_cmd_i);
		end
		if (wr_valid_i && wr_ready_o) begin
			wr_log.push_back(wr_cmd_i);
		end
	end
endmodule

// file: testbench/dxa_active_state_tb_top.sv
// Purpose: self-checking bench for the transfer working-state block
// Assumes: default DEPTH and a 16-byte burst; first request lands in set 0
// Notes: expected command streams are rebuilt from the request alone
module dxa_active_state_tb_top
	import dxa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, tr_valid_i, tr_ready_o, slow, hold;
	logic rd_valid_o, rd_ready_i, wr_valid_o, wr_ready_i, done_o;
	logic [7:0] adr_i;
	logic [31:0] dat_i, dat_o;
	logic [3:0] sel_i;
	dxa_tr_t tr_i;
	dxa_cmd_t rd_cmd_o, wr_cmd_o;
	dxa_done_t done_info_o;
	int fails, num_checks;
	dxa_active_state i_dxa_active_state (.*);
	dxa_endpoint_model i_dxa_endpoint_model (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .hold_wr_i(hold),
		.rd_valid_i(rd_valid_o), .rd_cmd_i(rd_cmd_o), .wr_valid_i(wr_valid_o), .wr_cmd_i(wr_cmd_o),
		.rd_ready_o(rd_ready_i), .wr_ready_o(wr_ready_i));
	// free-running clock
	initial begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic complete_run();
		if (fails == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait for ack (0), request ready (1) or done (2)
	task automatic wait_for(input int s, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			if (n > lim) begin
				fails++;
				complete_run();
			end
		end while ((s == 0 ? ack_o : s == 1 ? tr_ready_o : done_o) !== 1'h1);
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		wait_for(0, 20);
		q = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'h0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic submit(input dxa_tr_t t);
		i_dxa_endpoint_model.rd_log.delete();
		i_dxa_endpoint_model.wr_log.delete();
		@(posedge clk_i);
		tr_i <= t;
		tr_valid_i <= 1'h1;
		wait_for(1, 3000);
		tr_valid_i <= 1'h0;
	endtask
	// rebuild the command stream of one side and compare it entry by entry
	task automatic check_log(input dxa_tr_t t, input logic w);
		dxa_cmd_t q[$];
		logic [31:0] b, a;
		logic [15:0] lim, rem, n, s;
		logic wrap;
		int k;
		if (w) begin
			q = i_dxa_endpoint_model.wr_log;
		end else begin
			q = i_dxa_endpoint_model.rd_log;
		end
		wrap = w ? t.opt[1] : t.opt[0];
		lim = !wrap ? 16'h0010 : (t.opt[10:8] > 3'h5) ? 16'h0001 : 16'h0001 << t.opt[10:8];
		b = w ? t.dst : t.src;
		s = w ? t.didx : t.sidx;
		k = 0;
		for (int j = 0; j < t.array_count; j++) begin
			a = b;
			rem = t.first_dim_byte_count;
			while (rem != 16'h0) begin
				n = rem < lim ? rem : lim;
				chk(q[k].addr, a);
				chk(q[k].len, n);
				chk({q[k].transfer_priority, q[k].privilege_level, q[k].pid}, {t.opt[6:4], t.privilege_level, t.pid});
				a = wrap ? a : a + n;
				rem = rem - n;
				k++;
			end
			b = b + {{16{s[15]}}, s};
		end
		chk(32'(q.size()), 32'(k));
	endtask
	// reset values, a read-only write and an unmapped place
	task automatic t_regs();
		logic [7:0] offs[] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h40,
			8'h44, 8'h48, 8'h4C, 8'h60, 8'hAC};
		logic [31:0] q;
		foreach (offs[i]) rd(offs[i], 32'h0);
		wb(1'h1, 8'h18, 32'hFFFF_FFFF, q);
		rd(8'h18, 32'h0);
		wb(1'h1, 8'hFC, 32'hFFFF_FFFF, q);
		rd(8'hFC, 32'h0);
	endtask
	// two arrays, negative write stride, writes parked while software looks and edits
	task automatic t_increment_addressing();
		dxa_tr_t t;
		logic [31:0] q;
		t = '{opt: 32'h0042_A070, src: 32'h1000_0000, dst: 32'h2000_0100, first_dim_byte_count: 16'h0014, array_count: 16'h0002,
			sidx: 16'h0100, didx: 16'hFFF0, privilege_level: 1'h1, pid: 4'h1, default: 32'h0};
		hold <= 1'h1;
		submit(t);
		wait_for(1, 200);
		check_log(t, 1'h0);
		rd(8'h08, 32'h0);
		rd(8'h18, 32'h14);
		rd(8'h14, 32'h101);
		rd(8'h10, 32'h100);
		rd(8'h0C, 32'h0);
		rd(8'h20, 32'h0);
		rd(8'h40, t.opt);
		rd(8'h44, 32'h14);
		rd(8'h48, 32'h0);
		rd(8'h4C, t.dst);
		sel_i <= 4'h4;
		wb(1'h1, 8'h40, 32'h0002_0000, q);
		sel_i <= 4'hF;
		rd(8'h40, 32'h0002_A070);
		hold <= 1'h0;
		wait_for(2, 200);
		check_log(t, 1'h1);
		chk(done_info_o.chain, 1'h0);
		chk(done_info_o.code, 6'h2A);
	endtask
	// wrap on both sides through every width code and priority, slow endpoint
	task automatic t_wrap();
		dxa_tr_t t;
		logic [2:0] f;
		slow <= 1'h1;
		for (int i = 0; i < 8; i++) begin
			f = 3'(i);
			t = '{opt: {9'h0, f[0], 1'h0, f[1], 2'h0, 3'h0, f, 1'h0, f, 1'h0, f, 4'h3}, src: 32'h3000_0000,
				dst: 32'h4000_0000, first_dim_byte_count: 16'h0028, array_count: 16'h0002, sidx: 16'h0040, didx: 16'h0080,
				privilege_level: f[1], pid: {1'h0, f}, default: 32'h0};
			submit(t);
			wait_for(2, 3000);
			check_log(t, 1'h0);
			check_log(t, 1'h1);
			chk(done_info_o.chain, f[0]);
			chk(done_info_o.irq, f[1]);
			chk(done_info_o.code, {3'h0, f});
		end
		slow <= 1'h0;
	endtask
	// zero byte count retires with no commands
	task automatic t_zero();
		dxa_tr_t t;
		t = '{first_dim_byte_count: 16'h0, array_count: 16'h0003, src: 32'h5000_0000, default: '0};
		submit(t);
		wait_for(2, 50);
		check_log(t, 1'h0);
		check_log(t, 1'h1);
	endtask
	// main sequence
	initial begin
		{cyc_i, stb_i, we_i, tr_valid_i, slow, hold} = 6'h0;
		adr_i = 8'h0;
		dat_i = 32'h0;
		sel_i = 4'hF;
		tr_i = '0;
		rst_i = 1'h1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		t_regs();
		t_increment_addressing();
		t_wrap();
		t_zero();
		complete_run();
	end
endmodule
